// *** core/smlc_pkg.sv ***
package smlc_pkg;

   // Programming word and address field
   localparam int WORD_W = 32;
   localparam int ADDR_MSB = 2;
   localparam int ADDR_LSB = 0;
   localparam logic [2:0] ADDR_FREQ = 3'h0;
   localparam logic [2:0] ADDR_MOD = 3'h1;
   localparam logic [2:0] ADDR_LOOP = 3'h2;
   localparam logic [2:0] ADDR_OUTDIV = 3'h4;
   localparam logic [2:0] ADDR_PINMSB = 3'h5;

   // Reset images of the two configuration words
   localparam logic [31:0] MOD_RST = 32'h2000FFF9;
   localparam logic [31:0] LOOP_RST = 32'h00004042;

   // Modulus word layout
   localparam int MOD_MSB = 14;
   localparam int MOD_LSB = 3;

   // Loop configuration word layout
   localparam int RATE_BIT = 31;
   localparam int NOISE_MSB = 30;
   localparam int NOISE_LSB = 29;
   localparam int SEL_MSB = 28;
   localparam int SEL_LSB = 26;
   localparam int DBL_BIT = 25;
   localparam int HALF_BIT = 24;
   localparam int RDIV_MSB = 23;
   localparam int RDIV_LSB = 14;
   localparam int BUF_BIT = 13;
   localparam int CP_MSB = 12;
   localparam int CP_LSB = 9;
   localparam int ALG_BIT = 8;
   localparam int WIN_BIT = 7;
   localparam int POL_BIT = 6;
   localparam int PD_BIT = 5;
   localparam int HIZ_BIT = 4;
   localparam int CRST_BIT = 3;

   // Output divider setting and pin select top bit in other words
   localparam int OUTDIV_MSB = 22;
   localparam int OUTDIV_LSB = 20;
   localparam logic [2:0] OUTDIV_RST = 3'h0;
   localparam int PINMSB_BIT = 18;
   localparam logic PINMSB_RST = 1'b0;

   // Output pin select codes
   localparam logic [3:0] SEL_HIZ = 4'h0;
   localparam logic [3:0] SEL_HIGH = 4'h1;
   localparam logic [3:0] SEL_LOW = 4'h2;
   localparam logic [3:0] SEL_REFDIV = 4'h3;
   localparam logic [3:0] SEL_FBHALF = 4'h4;
   localparam logic [3:0] SEL_ALD = 4'h5;
   localparam logic [3:0] SEL_DLD = 4'h6;
   localparam logic [3:0] SEL_READBACK = 4'hC;

   // Modulator noise mode codes
   localparam logic [1:0] NOISE_LOW = 2'h0;
   localparam logic [1:0] NOISE_SPUR1 = 2'h2;
   localparam logic [1:0] NOISE_SPUR2 = 2'h3;

   // Active configuration handed to the synthesizer core
   typedef struct packed {
      logic lock_detect_rate;
      logic [1:0] modulator_noise_mode;
      logic [3:0] output_pin_select;
      logic reference_doubler_enable;
      logic reference_halver_enable;
      logic [9:0] reference_divide;
      logic output_divider_buffering_enable;
      logic [3:0] charge_pump_current_code;
      logic lock_detect_algorithm;
      logic lock_detect_window;
      logic detector_polarity;
      logic power_down;
      logic charge_pump_hiz;
      logic counter_reset;
      logic [11:0] modulus;
      logic [2:0] output_divider_setting;
   } smlc_cfg_t;

endpackage : smlc_pkg

// *** core/smlc_serial_rx.sv ***
`timescale 1ns/10ps
module smlc_serial_rx #(
   parameter int WORD_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic ser_load_i,
   output logic clk_rise_o,
   output logic word_valid_o,
   output logic [WORD_W-1:0] word_o
);
   localparam int CNT_W = $clog2(WORD_W + 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(WORD_W);

   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic clk_d_r;
   logic load_d_r;
   logic load_rise;
   logic [WORD_W-1:0] shift_r, shift_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic valid_nxt;
   logic [WORD_W-1:0] word_nxt;

   // Pins pass two flops; edges are taken from the second stage only.
   // Load resets to its idle high level so release shows no false edge.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 3'h4;
         sync_r <= 3'h4;
         clk_d_r <= 1'b0;
         load_d_r <= 1'b1;
      end else begin
         meta_r <= {ser_load_i, ser_data_i, ser_clk_i};
         sync_r <= meta_r;
         clk_d_r <= sync_r[0];
         load_d_r <= sync_r[2];
      end
   end

   assign clk_rise_o = sync_r[0] & ~clk_d_r;
   assign load_rise = sync_r[2] & ~load_d_r;

   // Shift while load is low; only a word of at least 32 bits is accepted
   always_comb begin
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      valid_nxt = 1'b0;
      word_nxt = word_o;
      if (load_rise) begin
         cnt_nxt = '0;
         if (cnt_r == FULL) begin
            valid_nxt = 1'b1;
            word_nxt = shift_r;
         end
      end else if (clk_rise_o && !sync_r[2]) begin
         shift_nxt = {shift_r[WORD_W-2:0], sync_r[1]};
         if (cnt_r != FULL) begin
            cnt_nxt = cnt_r + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_r <= '0;
         cnt_r <= '0;
         word_valid_o <= 1'b0;
         word_o <= '0;
      end else begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         word_valid_o <= valid_nxt;
         word_o <= word_nxt;
      end
   end

endmodule : smlc_serial_rx

// *** core/smlc_multiplexed_output_pin.sv ***
`timescale 1ns/10ps
module smlc_multiplexed_output_pin (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] sel_i,
   input wire logic ref_div_i,
   input wire logic fb_div_i,
   input wire logic analog_lock_i,
   input wire logic digital_lock_i,
   input wire logic readback_bit_i,
   output logic pin_o,
   output logic pin_oe_o
);
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic fb_d_r;
   logic half_r, half_nxt;
   logic pin_nxt;
   logic oe_nxt;

   // Divider and lock levels come from other circuits: two flops first
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 4'h0;
         sync_r <= 4'h0;
         fb_d_r <= 1'b0;
      end else begin
         meta_r <= {digital_lock_i, analog_lock_i, fb_div_i, ref_div_i};
         sync_r <= meta_r;
         fb_d_r <= sync_r[1];
      end
   end

   // Pin source by select code; reserved codes leave the pin undriven
   always_comb begin
      half_nxt = half_r ^ (sync_r[1] & ~fb_d_r);
      pin_nxt = 1'b0;
      oe_nxt = 1'b1;
      unique case (sel_i)
         smlc_pkg::SEL_HIGH: pin_nxt = 1'b1;
         smlc_pkg::SEL_LOW: pin_nxt = 1'b0;
         smlc_pkg::SEL_REFDIV: pin_nxt = sync_r[0];
         smlc_pkg::SEL_FBHALF: pin_nxt = half_r;
         smlc_pkg::SEL_ALD: pin_nxt = sync_r[2];
         smlc_pkg::SEL_DLD: pin_nxt = sync_r[3];
         smlc_pkg::SEL_READBACK: pin_nxt = readback_bit_i;
         default: oe_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_r <= 1'b0;
         pin_o <= 1'b0;
         pin_oe_o <= 1'b0;
      end else begin
         half_r <= half_nxt;
         pin_o <= pin_nxt;
         pin_oe_o <= oe_nxt;
      end
   end

endmodule : smlc_multiplexed_output_pin

// *** core/smlc_regs.sv ***
`timescale 1ns/10ps
module smlc_regs #(
   parameter int WORD_W = smlc_pkg::WORD_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic ser_load_i,
   input wire logic ref_div_i,
   input wire logic fb_div_i,
   input wire logic analog_lock_i,
   input wire logic digital_lock_i,
   input wire logic [WORD_W-1:0] readback_word_i,
   output smlc_pkg::smlc_cfg_t cfg_o,
   output logic [1:0] noise_mode_eff_o,
   output logic freq_word_load_o,
   output logic multiplexed_output_pin_o,
   output logic multiplexed_output_pin_oe_o
);

   // Serial front end outputs
   logic ser_clk_rise;
   logic word_valid;
   logic [WORD_W-1:0] word;
   logic [2:0] word_addr;

   // Written words and active copies of the buffered fields
   logic [WORD_W-1:0] mod_word_r, mod_word_nxt;
   logic [WORD_W-1:0] loop_word_r, loop_word_nxt;
   logic [11:0] mod_act_r, mod_act_nxt;
   logic [9:0] rdiv_act_r, rdiv_act_nxt;
   logic [3:0] cp_act_r, cp_act_nxt;
   logic [2:0] div_pend_r, div_pend_nxt;
   logic [2:0] div_act_r, div_act_nxt;
   logic pin_msb_r, pin_msb_nxt;
   logic load_r, load_nxt;

   // Readback shifter
   logic [WORD_W-1:0] rb_shift_r, rb_shift_nxt;

   // Decoded views of the stored words
   logic buffering_on;
   logic [3:0] pin_select;
   logic [1:0] noise_raw;

   smlc_serial_rx #(
      .WORD_W(WORD_W)
   ) u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ser_clk_i(ser_clk_i),
      .ser_data_i(ser_data_i),
      .ser_load_i(ser_load_i),
      .clk_rise_o(ser_clk_rise),
      .word_valid_o(word_valid),
      .word_o(word)
   );

   // Address field of the word just completed
   assign word_addr = word[smlc_pkg::ADDR_MSB:smlc_pkg::ADDR_LSB];

   // Live views; the select top bit lives in a separate word
   assign buffering_on = loop_word_r[smlc_pkg::BUF_BIT];
   assign pin_select = {pin_msb_r, loop_word_r[smlc_pkg::SEL_MSB:smlc_pkg::SEL_LSB]};
   assign noise_raw = loop_word_r[smlc_pkg::NOISE_MSB:smlc_pkg::NOISE_LSB];

   // Word storage and the double buffer transfer.
   // Pending values sit in the stored words; a word-zero write copies
   // them into the active set, so a half-written setup never reaches
   // the loop. Power-down is only a field: nothing here clears on it.
   always_comb begin
      mod_word_nxt = mod_word_r;
      loop_word_nxt = loop_word_r;
      mod_act_nxt = mod_act_r;
      rdiv_act_nxt = rdiv_act_r;
      cp_act_nxt = cp_act_r;
      div_pend_nxt = div_pend_r;
      div_act_nxt = div_act_r;
      pin_msb_nxt = pin_msb_r;
      load_nxt = 1'b0;
      if (word_valid) begin
         unique case (word_addr)
            smlc_pkg::ADDR_FREQ: begin
               // Apply pending buffered fields; the output divider only with buffering on
               mod_act_nxt = mod_word_r[smlc_pkg::MOD_MSB:smlc_pkg::MOD_LSB];
               rdiv_act_nxt = loop_word_r[smlc_pkg::RDIV_MSB:smlc_pkg::RDIV_LSB];
               cp_act_nxt = loop_word_r[smlc_pkg::CP_MSB:smlc_pkg::CP_LSB];
               if (buffering_on) begin
                  div_act_nxt = div_pend_r;
               end
               load_nxt = 1'b1;
            end
            smlc_pkg::ADDR_MOD: begin
               mod_word_nxt = word;
            end
            smlc_pkg::ADDR_LOOP: begin
               loop_word_nxt = word;
            end
            smlc_pkg::ADDR_OUTDIV: begin
               div_pend_nxt = word[smlc_pkg::OUTDIV_MSB:smlc_pkg::OUTDIV_LSB];
               if (!buffering_on) begin
                  div_act_nxt = word[smlc_pkg::OUTDIV_MSB:smlc_pkg::OUTDIV_LSB];
               end
            end
            smlc_pkg::ADDR_PINMSB: begin
               pin_msb_nxt = word[smlc_pkg::PINMSB_BIT];
            end
            default: begin
               // Words outside this block leave every field unchanged
               load_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mod_word_r <= smlc_pkg::MOD_RST;
         loop_word_r <= smlc_pkg::LOOP_RST;
         mod_act_r <= smlc_pkg::MOD_RST[smlc_pkg::MOD_MSB:smlc_pkg::MOD_LSB];
         rdiv_act_r <= smlc_pkg::LOOP_RST[smlc_pkg::RDIV_MSB:smlc_pkg::RDIV_LSB];
         cp_act_r <= smlc_pkg::LOOP_RST[smlc_pkg::CP_MSB:smlc_pkg::CP_LSB];
         div_pend_r <= smlc_pkg::OUTDIV_RST;
         div_act_r <= smlc_pkg::OUTDIV_RST;
         pin_msb_r <= smlc_pkg::PINMSB_RST;
         load_r <= 1'b0;
      end else begin
         mod_word_r <= mod_word_nxt;
         loop_word_r <= loop_word_nxt;
         mod_act_r <= mod_act_nxt;
         rdiv_act_r <= rdiv_act_nxt;
         cp_act_r <= cp_act_nxt;
         div_pend_r <= div_pend_nxt;
         div_act_r <= div_act_nxt;
         pin_msb_r <= pin_msb_nxt;
         load_r <= load_nxt;
      end
   end

   assign freq_word_load_o = load_r;

   // Readback: the snapshot is taken when a word completes while the
   // pin is in readback mode, then one bit per serial clock rise, msb
   // first. The host clocks it out with load held high.
   always_comb begin
      rb_shift_nxt = rb_shift_r;
      if (word_valid && pin_select == smlc_pkg::SEL_READBACK) begin
         rb_shift_nxt = readback_word_i;
      end else if (ser_clk_rise) begin
         rb_shift_nxt = {rb_shift_r[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rb_shift_r <= '0;
      end else begin
         rb_shift_r <= rb_shift_nxt;
      end
   end

   // Pin driver; its output comes from flops inside
   smlc_multiplexed_output_pin u_mux (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(pin_select),
      .ref_div_i(ref_div_i),
      .fb_div_i(fb_div_i),
      .analog_lock_i(analog_lock_i),
      .digital_lock_i(digital_lock_i),
      .readback_bit_i(rb_shift_r[WORD_W-1]),
      .pin_o(multiplexed_output_pin_o),
      .pin_oe_o(multiplexed_output_pin_oe_o)
   );

   // Immediate fields straight from the stored word, buffered fields from the active copies; the loop core
   // decodes them, the bank only carries them out.
   assign cfg_o.lock_detect_rate = loop_word_r[smlc_pkg::RATE_BIT];
   assign cfg_o.modulator_noise_mode = noise_raw;
   assign cfg_o.output_pin_select = pin_select;
   assign cfg_o.reference_doubler_enable = loop_word_r[smlc_pkg::DBL_BIT];
   assign cfg_o.reference_halver_enable = loop_word_r[smlc_pkg::HALF_BIT];
   assign cfg_o.reference_divide = rdiv_act_r;
   assign cfg_o.output_divider_buffering_enable = buffering_on;
   assign cfg_o.charge_pump_current_code = cp_act_r;
   assign cfg_o.lock_detect_algorithm = loop_word_r[smlc_pkg::ALG_BIT];
   assign cfg_o.lock_detect_window = loop_word_r[smlc_pkg::WIN_BIT];
   assign cfg_o.detector_polarity = loop_word_r[smlc_pkg::POL_BIT];
   assign cfg_o.power_down = loop_word_r[smlc_pkg::PD_BIT];
   assign cfg_o.charge_pump_hiz = loop_word_r[smlc_pkg::HIZ_BIT];
   assign cfg_o.counter_reset = loop_word_r[smlc_pkg::CRST_BIT];
   assign cfg_o.modulus = mod_act_r;
   assign cfg_o.output_divider_setting = div_act_r;

   // Effective noise mode: the reserved code falls back to low noise
   // so noise_mode_eff_o never shows an undefined setting; cfg_o carries the raw code
   always_comb begin
      unique case (noise_raw)
         smlc_pkg::NOISE_SPUR1: noise_mode_eff_o = smlc_pkg::NOISE_SPUR1;
         smlc_pkg::NOISE_SPUR2: noise_mode_eff_o = smlc_pkg::NOISE_SPUR2;
         default: noise_mode_eff_o = smlc_pkg::NOISE_LOW;
      endcase
   end

endmodule : smlc_regs

// *** dv/smlc_regs_assertions.sv ***
`timescale 1ns/10ps
module smlc_regs_assertions #(
   parameter int WORD_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic ser_load_i,
   input wire logic ref_div_i,
   input wire logic fb_div_i,
   input wire logic analog_lock_i,
   input wire logic digital_lock_i,
   input wire logic [WORD_W-1:0] readback_word_i,
   input wire smlc_pkg::smlc_cfg_t cfg_o,
   input wire logic [1:0] noise_mode_eff_o,
   input wire logic freq_word_load_o,
   input wire logic multiplexed_output_pin_o,
   input wire logic multiplexed_output_pin_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] since_load_r;
   logic [3:0] sel;
   assign sel = cfg_o.output_pin_select;
   // Cycles since the load pin rose; saturates so long idle spans cannot wrap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) since_load_r <= 4'hF;
      else if ($rose(ser_load_i)) since_load_r <= 4'h0;
      else if (since_load_r != 4'hF) since_load_r <= since_load_r + 4'h1;
   end
   sequence s_load_rise;
      $rose(ser_load_i);
   endsequence
   a_pulse_single: assert property (freq_word_load_o |=> !freq_word_load_o)
      else $error("apply pulse longer than one cycle");
   a_cfg_quiet: assert property (s_load_rise |=> $stable(cfg_o) [*2])
      else $error("configuration moved too soon after load");
   a_cfg_after_load: assert property (!$stable(cfg_o) |-> since_load_r inside {[4'h2:4'h8]})
      else $error("configuration moved without a word");
   a_mod_buffered: assert property (!$stable(cfg_o.modulus) |-> freq_word_load_o)
      else $error("modulus changed without apply");
   a_rdiv_buffered: assert property (!$stable(cfg_o.reference_divide) |-> freq_word_load_o)
      else $error("reference divide changed without apply");
   a_cp_buffered: assert property (!$stable(cfg_o.charge_pump_current_code) |-> freq_word_load_o)
      else $error("pump current changed without apply");
   a_noise_map: assert property (noise_mode_eff_o == ((cfg_o.modulator_noise_mode == 2'h1) ?
      2'h0 : cfg_o.modulator_noise_mode))
      else $error("effective noise mode wrong");
   a_pin_hiz: assert property (sel == smlc_pkg::SEL_HIZ |=> !multiplexed_output_pin_oe_o)
      else $error("pin driven in three-state select");
   a_pin_reserved: assert property (sel inside {[4'h7:4'hB], [4'hD:4'hF]} |=>
      !multiplexed_output_pin_oe_o)
      else $error("pin driven on reserved select");
   a_pin_high: assert property (sel == smlc_pkg::SEL_HIGH |=>
      multiplexed_output_pin_oe_o && multiplexed_output_pin_o)
      else $error("pin not high");
   a_pin_low: assert property (sel == smlc_pkg::SEL_LOW |=>
      multiplexed_output_pin_oe_o && !multiplexed_output_pin_o)
      else $error("pin not low");
endmodule : smlc_regs_assertions

// *** dv/smlc_host_model.sv ***
`timescale 1ns/10ps
module smlc_host_model (
   input wire logic clk_i,
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic ser_load_o
);
   // Link idles with clock low and load high
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      ser_load_o = 1'b1;
   end
   // Four cycles per level so the two-flop sync never misses an edge
   task automatic hold4();
      repeat (4) @(negedge clk_i);
   endtask : hold4
   task automatic pulse();
      ser_clk_o = 1'b1;
      hold4();
      ser_clk_o = 1'b0;
      hold4();
   endtask : pulse
   // Word top bit first, address in the low three bits; a short count cuts it
   task automatic send_word(input logic [31:0] w, input int nbits = 32);
      @(negedge clk_i);
      ser_load_o = 1'b0;
      for (int i = 31; i > 31 - nbits; i--) begin
         ser_data_o = w[i];
         hold4();
         pulse();
      end
      ser_load_o = 1'b1;
      ser_data_o = ~w[0]; // Released line shows no stale bit
      hold4();
   endtask : send_word
endmodule : smlc_host_model

// *** dv/tb_smlc_regs.sv ***
`timescale 1ns/10ps
module tb_smlc_regs;
   localparam int WORD_W = 32;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ser_clk, ser_data, ser_load, freq_load, pin, pin_oe, ep, eo;
   logic ref_div_i = 1'b0;
   logic fb_div_i = 1'b0;
   logic ald_i = 1'b0;
   logic dld_i = 1'b0;
   logic [31:0] rb_word = 32'h0;
   logic [1:0] noise_eff;
   smlc_pkg::smlc_cfg_t cfg_o;
   int miscompares = 0;
   int num_checks = 0;
   logic [31:0] rng = 32'h00017ED7;
   logic [31:0] mod_w, loop_w, w;
   logic [11:0] a_mod;
   logic [9:0] a_rdiv;
   logic [3:0] a_cp;
   logic [2:0] p_div, a_div;
   logic top_b;
   logic fb_half;

   always #5 clk_i = ~clk_i;

   smlc_host_model smlc_host_model_i (.clk_i(clk_i), .ser_clk_o(ser_clk),
      .ser_data_o(ser_data), .ser_load_o(ser_load));
   smlc_regs #(.WORD_W(WORD_W)) smlc_regs_i (.clk_i(clk_i), .rst_i(rst_i),
      .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_load_i(ser_load),
      .ref_div_i(ref_div_i), .fb_div_i(fb_div_i), .analog_lock_i(ald_i),
      .digital_lock_i(dld_i), .readback_word_i(rb_word), .cfg_o(cfg_o),
      .noise_mode_eff_o(noise_eff), .freq_word_load_o(freq_load),
      .multiplexed_output_pin_o(pin), .multiplexed_output_pin_oe_o(pin_oe));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   // Active configuration as the model sees it
   function automatic smlc_pkg::smlc_cfg_t exp_cfg();
      return smlc_pkg::smlc_cfg_t'({loop_w[31:29], top_b, loop_w[28:24], a_rdiv,
         loop_w[13], a_cp, loop_w[8:3], a_mod, a_div});
   endfunction : exp_cfg

   task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // Reset, then compare against the reset images
   task automatic do_reset();
      rst_i = 1'b1;
      mod_w = smlc_pkg::MOD_RST;
      loop_w = smlc_pkg::LOOP_RST;
      a_mod = mod_w[14:3];
      a_rdiv = loop_w[23:14];
      a_cp = loop_w[12:9];
      p_div = smlc_pkg::OUTDIV_RST;
      a_div = smlc_pkg::OUTDIV_RST;
      top_b = smlc_pkg::PINMSB_RST;
      fb_half = 1'b0;
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check("reset cfg", 64'(exp_cfg()), 64'(cfg_o));
      check("reset oe", 64'h0, 64'(pin_oe));
      $display("test reset done");
   endtask : do_reset

   // Send one word, update the model, compare once the word has landed
   task automatic wr(input logic [31:0] d);
      smlc_host_model_i.send_word(d);
      case (d[2:0])
         3'h0: begin
            a_mod = mod_w[14:3];
            a_rdiv = loop_w[23:14];
            a_cp = loop_w[12:9];
            if (loop_w[13]) a_div = p_div;
         end
         3'h1: mod_w = d;
         3'h2: loop_w = d;
         3'h4: begin
            p_div = d[22:20];
            if (!loop_w[13]) a_div = d[22:20];
         end
         3'h5: top_b = d[18];
         default: ;
      endcase
      repeat (10) @(negedge clk_i);
      check("cfg", 64'(exp_cfg()), 64'(cfg_o));
      check("noise", 64'(loop_w[30:29] & {loop_w[30], 1'b1}), 64'(noise_eff));
   endtask : wr

   initial begin
      do_reset();
      // Random words over every address; host keeps used noise codes only
      for (int n = 0; n < 24; n++) begin
         w = xs();
         w[2:0] = 3'(n);
         if (n % 8 == 1) w[4] = 1'b1;
         if (n % 8 == 2) w[14] = 1'b1;
         if (n % 8 == 2 && w[30:29] == 2'h1) w[29] = 1'b0;
         if (n % 8 == 0) w[31] = loop_w[8];
         wr(w);
      end
      // A cut word must be dropped whole, whichever address it would decode to
      w = xs();
      w[3:0] = 4'h4;
      smlc_host_model_i.send_word(w, 31);
      repeat (10) @(negedge clk_i);
      check("cut word", 64'(exp_cfg()), 64'(cfg_o));
      $display("test random done");
      do_reset();
      // Sweep every select code with fresh source levels
      for (int c = 0; c < 16; c++) begin
         w = xs();
         if (w[3] && !fb_div_i) fb_half = ~fb_half;
         fb_div_i = w[3];
         ref_div_i = w[0];
         ald_i = w[1];
         dld_i = w[2];
         rb_word = w;
         w = loop_w;
         w[28:26] = c[2:0];
         wr(w);
         wr({13'h0, c[3], 15'h0, 3'h5});
         // Ignored address, takes the readback snapshot
         wr(32'h00000007);
         case (c)
            1: ep = 1'b1;
            2: ep = 1'b0;
            3: ep = ref_div_i;
            4: ep = fb_half;
            5: ep = ald_i;
            6: ep = dld_i;
            12: ep = rb_word[31];
            default: ep = 1'b0;
         endcase
         eo = (c >= 1 && c <= 6) || c == 12;
         check("pin oe", 64'(eo), 64'(pin_oe));
         if (eo) check("pin", 64'(ep), 64'(pin));
         if (c == 12) begin
            smlc_host_model_i.pulse();
            check("readback bit", 64'(rb_word[30]), 64'(pin));
         end
      end
      $display("test pin select done");
      complete_run();
   end

   // Watchdog well beyond the expected run of about 29000 cycles
   initial begin
      repeat (80000) @(posedge clk_i);
      miscompares++;
      $display("Error watchdog expected done seen hang");
      complete_run();
   end
endmodule : tb_smlc_regs

bind smlc_regs smlc_regs_assertions #(.WORD_W(WORD_W)) smlc_regs_assertions_i (
   .clk_i(clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk_i), .ser_data_i(ser_data_i),
   .ser_load_i(ser_load_i), .ref_div_i(ref_div_i), .fb_div_i(fb_div_i),
   .analog_lock_i(analog_lock_i), .digital_lock_i(digital_lock_i),
   .readback_word_i(readback_word_i), .cfg_o(cfg_o), .noise_mode_eff_o(noise_mode_eff_o),
   .freq_word_load_o(freq_word_load_o), .multiplexed_output_pin_o(multiplexed_output_pin_o),
   .multiplexed_output_pin_oe_o(multiplexed_output_pin_oe_o));
